// ### core/rtxc_cfg.svh
`ifndef RTXC_CFG_SVH
`define RTXC_CFG_SVH

`define RTXC_OFS_PROM_LAST 8'h7c
`define RTXC_PROM_WORDS 32
`define RTXC_PROM_CSUM_IDX 28
`define RTXC_OFS_BIC 8'h80
`define RTXC_OFS_CTL 8'h84
`define RTXC_OFS_TXPTR 8'h88
`define RTXC_OFS_TXENT 8'h8c
`define RTXC_OFS_SEGPTR 8'h90
`define RTXC_OFS_PAGEPTR 8'h94
`define RTXC_OFS_RXENT 8'h98
`define RTXC_OFS_SENSE 8'h9c
`define RTXC_OFS_ISTAT 8'ha0
`define RTXC_OFS_SOFTCLR 8'ha4
`define RTXC_OFS_CMD_SRC 8'ha8
`define RTXC_OFS_CMD_CNT 8'hac
`define RTXC_OFS_CMD_DST 8'hb0
`define RTXC_OFS_SRC_CNTR 8'hb4
`define RTXC_OFS_BYTE_CNTR 8'hb8
`define RTXC_OFS_DST_CNTR 8'hbc
`define RTXC_CTL_ONLINE 0
`define RTXC_CTL_TX_OUT_EN 1
`define RTXC_CTL_MULTI_GRANT 2
`define RTXC_CTL_LOOPBACK 3
`define RTXC_TXPTR_P 16
`define RTXC_TXPTR_U 17
`define RTXC_TXENT_OPEN 3
`define RTXC_RX_SEG_OPEN 29
`define RTXC_RX_PAGE_OPEN 28
`define RTXC_RX_MAILBOX 27
`define RTXC_IS_DONE_STATUS 4
`define RTXC_IS_DMA_DONE 5
`define RTXC_IS_Q_DONE 6
`define RTXC_IS_SEQ_ERR 7
`define RTXC_SENSE_BLKSZ_LSB 8
`define RTXC_SENSE_ONLINE 16
`define RTXC_SENSE_STALL 17
`define RTXC_SENSE_HALTED 18
`define RTXC_SENSE_CMDQ_EMPTY 19
`define RTXC_NODE_ID_MAX 4'h9
`define RTXC_BLKSZ_8 8'h08
`define RTXC_BLKSZ_16 8'h10
`define RTXC_BLKSZ_32 8'h20
`define RTXC_DMA_STEP 32'h4
`define RTXC_RESET_WORD 32'h0
`endif

// ### core/rtxc_pkg.sv
package rtxc_pkg;
  // Snooped write seen on the expansion memory port
  typedef struct packed {
    logic valid;
    logic [28:0] addr;
    logic [31:0] data;
  } rtxc_snoop_type;
  // One word sent onto the replicated memory bus
  typedef struct packed {
    logic valid;
    logic [39:0] addr;
    logic [31:0] data;
  } rtxc_busword_type;
  // Queued DMA command
  typedef struct packed {
    logic [31:0] src;
    logic [31:0] cnt;
    logic [31:0] dst;
  } rtxc_cmd_type;
  typedef enum logic [1:0] {DMA_IDLE, DMA_RUN, DMA_FINISH} rtxc_dma_state_type;
  typedef enum logic [1:0] {CMD_WANT_SRC, CMD_WANT_CNT, CMD_WANT_DST} rtxc_cmd_phase_type;
endpackage

// ### core/rtxc_top.sv
`timescale 1ns/1ps
`include "rtxc_cfg.svh"
module rtxc_top #(
  parameter int TXF_DEPTH = 449,
  parameter int WIN_AW = 6,
  parameter int WIN_LSB = 13,
  parameter int SEG_AW = 4,
  parameter int PAGE_AW = 6,
  parameter int CMDF_DEPTH = 4,
  parameter logic [7:0] PROM_MARK = 8'h5a
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire rtxc_pkg::rtxc_snoop_type snoop_i,
  output logic stall_o,
  input wire logic [3:0] node_id_pin_i,
  input wire logic [1:0] blksz_pin_i,
  output logic bus_req_o,
  input wire logic bus_grant_i,
  output rtxc_pkg::rtxc_busword_type bus_word_o,
  output logic multi_grant_req_o,
  output logic dma_req_o,
  output logic [31:0] dma_addr_o,
  input wire logic dma_ack_i
);
  import rtxc_pkg::*;

  localparam int CW = $clog2(TXF_DEPTH + 1);
  localparam int QW = $clog2(CMDF_DEPTH + 1);
  localparam int PW = (CMDF_DEPTH > 1) ? $clog2(CMDF_DEPTH) : 1;
  localparam int FW = (TXF_DEPTH > 1) ? $clog2(TXF_DEPTH) : 1;
  localparam logic [CW-1:0] DEPTH_C = CW'(TXF_DEPTH);
  localparam logic [CW-1:0] HALF_C = CW'(TXF_DEPTH / 2);
  localparam logic [QW-1:0] QDEPTH_C = QW'(CMDF_DEPTH);

  // ==========================================================
  // Parameter checks
  generate
    if (TXF_DEPTH < 2 || CMDF_DEPTH < 1 || WIN_LSB + WIN_AW > 29 || WIN_LSB < 12) begin : g_bad_param
      $error("rtxc_top: unsupported parameter set");
    end
  endgenerate

  // ==========================================================
  // Identity store contents (pattern is arbitrary); checksum split over last four words
  function automatic logic [31:0] prom_word(input int idx);
    logic [31:0] sum;
    sum = 32'h0;
    for (int k = 0; k < `RTXC_PROM_CSUM_IDX; k++) begin
      sum = sum + {PROM_MARK, 8'(k), 8'h3c, 8'(k * 3)};
    end
    if (idx < `RTXC_PROM_CSUM_IDX) begin
      prom_word = {PROM_MARK, 8'(idx), 8'h3c, 8'(idx * 3)};
    end else begin
      prom_word = {24'h0, sum[8*(idx-`RTXC_PROM_CSUM_IDX) +: 8]};
    end
  endfunction

  // ==========================================================
  // Storage and state
  logic [31:0] bic_reg;
  logic [31:0] ctl_reg;
  logic [WIN_AW-1:0] txptr_win_reg;
  logic txptr_p_reg, txptr_u_reg;
  logic [31:0] tx_ram [0:(1<<WIN_AW)-1];
  logic [SEG_AW-1:0] segptr_reg;
  logic [PAGE_AW-1:0] pageptr_reg;
  logic seg_ram [0:(1<<SEG_AW)-1];
  logic [18:0] page_ram [0:(1<<PAGE_AW)-1];
  logic [3:0] ccid_reg;
  logic done_status_reg, dma_done_reg, q_done_reg, seq_err_reg, halted_reg;
  logic soft_clr_reg;
  logic [31:0] rdata_reg;
  logic [3:0] node_s1_reg, node_s2_reg, node_s3_reg, node_reg;
  logic [1:0] blksz_s1_reg, blksz_s2_reg, blksz_s3_reg, blksz_reg;
  rtxc_busword_type txf_mem [0:TXF_DEPTH-1];
  logic [FW-1:0] txf_wr_reg, txf_rd_reg;
  logic [CW-1:0] txf_cnt_reg, txf_cnt_next;
  logic stall_reg, bus_req_reg, multi_reg;
  rtxc_busword_type bus_word_reg;
  rtxc_cmd_type cmdq_mem [0:CMDF_DEPTH-1];
  rtxc_cmd_type cmd_stage_reg;
  rtxc_cmd_phase_type cmd_phase_reg;
  logic [PW-1:0] cmdq_wr_reg, cmdq_rd_reg;
  logic [QW-1:0] cmdq_cnt_reg;
  rtxc_dma_state_type dma_state_reg;
  logic [31:0] src_cntr_reg, byte_cntr_reg, dst_cntr_reg;
  logic [3:0] cmd_tag_reg;
  logic dma_req_reg;

  // Soft clear acts like reset on the cycle after the strobe; RAM contents, strap stages and read data survive it
  logic clr;
  assign clr = !reset_n_i || soft_clr_reg;

  // Decoded strobes
  logic wr_bic, wr_ctl, wr_txptr, wr_txent, wr_segptr, wr_pageptr, wr_rxent, wr_istat;
  logic wr_src, wr_cnt, wr_dst;
  assign wr_bic = wr_i && addr_i == `RTXC_OFS_BIC;
  assign wr_ctl = wr_i && addr_i == `RTXC_OFS_CTL;
  assign wr_txptr = wr_i && addr_i == `RTXC_OFS_TXPTR;
  assign wr_txent = wr_i && addr_i == `RTXC_OFS_TXENT;
  assign wr_segptr = wr_i && addr_i == `RTXC_OFS_SEGPTR;
  assign wr_pageptr = wr_i && addr_i == `RTXC_OFS_PAGEPTR;
  assign wr_rxent = wr_i && addr_i == `RTXC_OFS_RXENT;
  assign wr_istat = wr_i && addr_i == `RTXC_OFS_ISTAT;
  assign wr_src = wr_i && addr_i == `RTXC_OFS_CMD_SRC;
  assign wr_cnt = wr_i && addr_i == `RTXC_OFS_CMD_CNT;
  assign wr_dst = wr_i && addr_i == `RTXC_OFS_CMD_DST;

  // ==========================================================
  // Strap pins: three stages, a value counts once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      node_s1_reg <= 4'h0;
      node_s2_reg <= 4'h0;
      node_s3_reg <= 4'h0;
      node_reg <= 4'h0;
      blksz_s1_reg <= 2'h0;
      blksz_s2_reg <= 2'h0;
      blksz_s3_reg <= 2'h0;
      blksz_reg <= 2'h0;
    end else if (ce_i) begin
      node_s1_reg <= node_id_pin_i;
      node_s2_reg <= node_s1_reg;
      node_s3_reg <= node_s2_reg;
      blksz_s1_reg <= blksz_pin_i;
      blksz_s2_reg <= blksz_s1_reg;
      blksz_s3_reg <= blksz_s2_reg;
      if (node_s2_reg == node_s3_reg) begin
        node_reg <= (node_s3_reg > `RTXC_NODE_ID_MAX) ? `RTXC_NODE_ID_MAX : node_s3_reg;
      end
      if (blksz_s2_reg == blksz_s3_reg) begin
        blksz_reg <= blksz_s3_reg;
      end
    end
  end

  // Subblock size code to binary byte count; unused code falls back to 8
  logic [7:0] blksz_val;
  always_comb begin
    case (blksz_reg)
      2'h1: blksz_val = `RTXC_BLKSZ_16;
      2'h2: blksz_val = `RTXC_BLKSZ_32;
      default: blksz_val = `RTXC_BLKSZ_8;
    endcase
  end

  // ==========================================================
  // Software control registers
  always_ff @(posedge clk_i) begin
    if (clr) begin
      bic_reg <= `RTXC_RESET_WORD;
      ctl_reg <= `RTXC_RESET_WORD;
      txptr_win_reg <= '0;
      txptr_p_reg <= 1'b0;
      txptr_u_reg <= 1'b0;
      segptr_reg <= '0;
      pageptr_reg <= '0;
    end else if (ce_i) begin
      if (wr_bic) bic_reg <= wdata_i;
      if (wr_ctl) ctl_reg <= wdata_i;
      if (wr_txptr) begin
        txptr_win_reg <= wdata_i[WIN_AW-1:0];
        txptr_p_reg <= wdata_i[`RTXC_TXPTR_P];
        txptr_u_reg <= wdata_i[`RTXC_TXPTR_U];
      end
      if (wr_segptr) segptr_reg <= wdata_i[SEG_AW-1:0];
      if (wr_pageptr) pageptr_reg <= wdata_i[PAGE_AW-1:0];
    end
  end

  // Soft clear strobe, held one cycle
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      soft_clr_reg <= 1'b0;
    end else if (ce_i) begin
      soft_clr_reg <= wr_i && addr_i == `RTXC_OFS_SOFTCLR && !soft_clr_reg;
    end
  end

  // Window tables; no reset, software initialises them
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (wr_txent) tx_ram[txptr_win_reg] <= wdata_i;
      if (wr_rxent) begin
        seg_ram[segptr_reg] <= wdata_i[`RTXC_RX_SEG_OPEN];
        page_ram[pageptr_reg] <= {wdata_i[`RTXC_RX_PAGE_OPEN], wdata_i[`RTXC_RX_MAILBOX], wdata_i[16:0]};
      end
    end
  end

  // ==========================================================
  // Read mux; data valid in the cycle after the strobe only
  logic [31:0] rd_mux;
  logic [31:0] rx_word;
  logic [31:0] istat_word;
  logic [31:0] sense_word;
  logic [31:0] ptr_word;
  always_comb begin
    rx_word = 32'h0;
    rx_word[`RTXC_RX_SEG_OPEN] = seg_ram[segptr_reg];
    rx_word[`RTXC_RX_PAGE_OPEN] = page_ram[pageptr_reg][18];
    rx_word[`RTXC_RX_MAILBOX] = page_ram[pageptr_reg][17];
    rx_word[16:0] = page_ram[pageptr_reg][16:0];
    istat_word = {24'h0, seq_err_reg, q_done_reg, dma_done_reg, done_status_reg, ccid_reg};
    sense_word = 32'h0;
    sense_word[3:0] = node_reg;
    sense_word[`RTXC_SENSE_BLKSZ_LSB +: 8] = blksz_val;
    sense_word[`RTXC_SENSE_ONLINE] = ctl_reg[`RTXC_CTL_ONLINE];
    sense_word[`RTXC_SENSE_STALL] = stall_reg;
    sense_word[`RTXC_SENSE_HALTED] = halted_reg;
    sense_word[`RTXC_SENSE_CMDQ_EMPTY] = cmdq_cnt_reg == '0;
    ptr_word = 32'h0;
    ptr_word[WIN_AW-1:0] = txptr_win_reg;
    ptr_word[`RTXC_TXPTR_P] = txptr_p_reg;
    ptr_word[`RTXC_TXPTR_U] = txptr_u_reg;
    if (addr_i <= `RTXC_OFS_PROM_LAST) begin
      rd_mux = prom_word(int'(addr_i[6:2]));
    end else begin
      case (addr_i)
        `RTXC_OFS_BIC: rd_mux = bic_reg;
        `RTXC_OFS_CTL: rd_mux = ctl_reg;
        `RTXC_OFS_TXPTR: rd_mux = ptr_word;
        `RTXC_OFS_TXENT: rd_mux = tx_ram[txptr_win_reg];
        `RTXC_OFS_SEGPTR: rd_mux = 32'(segptr_reg);
        `RTXC_OFS_PAGEPTR: rd_mux = 32'(pageptr_reg);
        `RTXC_OFS_RXENT: rd_mux = rx_word;
        `RTXC_OFS_SENSE: rd_mux = sense_word;
        `RTXC_OFS_ISTAT: rd_mux = istat_word;
        `RTXC_OFS_SRC_CNTR: rd_mux = src_cntr_reg;
        `RTXC_OFS_BYTE_CNTR: rd_mux = byte_cntr_reg;
        `RTXC_OFS_DST_CNTR: rd_mux = dst_cntr_reg;
        default: rd_mux = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rdata_reg <= 32'h0;
    end else if (ce_i) begin
      rdata_reg <= rd_i ? rd_mux : 32'h0;
    end
  end

  // ==========================================================
  // Snoop path and transmit FIFO
  logic [31:0] snoop_ent;
  logic push, pop;
  assign snoop_ent = tx_ram[snoop_i.addr[WIN_LSB +: WIN_AW]];
  // Offline or stalled: the write still reaches memory, it is just not reflected
  assign push = snoop_i.valid && snoop_ent[`RTXC_TXENT_OPEN]
    && ctl_reg[`RTXC_CTL_ONLINE] && !stall_reg && txf_cnt_reg != DEPTH_C;
  // Disabled output leaves entries in place
  assign pop = ctl_reg[`RTXC_CTL_TX_OUT_EN] && bus_req_reg && bus_grant_i && txf_cnt_reg != '0;

  always_comb begin
    txf_cnt_next = txf_cnt_reg;
    if (push && !pop) txf_cnt_next = txf_cnt_reg + CW'(1);
    if (pop && !push) txf_cnt_next = txf_cnt_reg - CW'(1);
  end

  always_ff @(posedge clk_i) begin
    if (ce_i && push) begin
      txf_mem[txf_wr_reg] <= '{valid: 1'b1, addr: {snoop_ent[31:4], snoop_i.addr[11:0]}, data: snoop_i.data};
    end
  end

  always_ff @(posedge clk_i) begin
    if (clr) begin
      txf_wr_reg <= '0;
      txf_rd_reg <= '0;
      txf_cnt_reg <= '0;
      stall_reg <= 1'b0;
    end else if (ce_i) begin
      if (push) txf_wr_reg <= (txf_wr_reg == FW'(TXF_DEPTH - 1)) ? '0 : txf_wr_reg + FW'(1);
      if (pop) txf_rd_reg <= (txf_rd_reg == FW'(TXF_DEPTH - 1)) ? '0 : txf_rd_reg + FW'(1);
      txf_cnt_reg <= txf_cnt_next;
      // Stall follows the fill level, so it drops the cycle after a pop frees a slot
      stall_reg <= txf_cnt_next == DEPTH_C;
    end
  end

  // Replicated bus side: request while data waits, one word per grant
  always_ff @(posedge clk_i) begin
    if (clr) begin
      bus_req_reg <= 1'b0;
      bus_word_reg <= '0;
      multi_reg <= 1'b0;
    end else if (ce_i) begin
      bus_req_reg <= ctl_reg[`RTXC_CTL_TX_OUT_EN] && txf_cnt_next != '0;
      bus_word_reg <= pop ? txf_mem[txf_rd_reg] : '0;
      multi_reg <= ctl_reg[`RTXC_CTL_MULTI_GRANT] && txf_cnt_next >= HALF_C;
    end
  end

  // ==========================================================
  // Command FIFO loading; writes must go source, count, destination
  logic cmd_seq_bad, cmd_push, cmd_pop;
  assign cmd_seq_bad = (wr_src && cmd_phase_reg != CMD_WANT_SRC)
    || (wr_cnt && cmd_phase_reg != CMD_WANT_CNT)
    || (wr_dst && (cmd_phase_reg != CMD_WANT_DST || cmdq_cnt_reg == QDEPTH_C));
  assign cmd_push = wr_dst && !cmd_seq_bad;
  assign cmd_pop = dma_state_reg == DMA_IDLE && !halted_reg && cmdq_cnt_reg != '0;

  always_ff @(posedge clk_i) begin
    if (ce_i && cmd_push) begin
      cmdq_mem[cmdq_wr_reg] <= '{src: cmd_stage_reg.src, cnt: cmd_stage_reg.cnt, dst: wdata_i};
    end
  end

  always_ff @(posedge clk_i) begin
    if (clr) begin
      cmd_stage_reg <= '0;
      cmd_phase_reg <= CMD_WANT_SRC;
      cmdq_wr_reg <= '0;
      cmdq_rd_reg <= '0;
      cmdq_cnt_reg <= '0;
    end else if (ce_i) begin
      if (cmd_seq_bad) begin
        cmd_phase_reg <= CMD_WANT_SRC;
      end else if (wr_src) begin
        cmd_stage_reg.src <= wdata_i;
        cmd_phase_reg <= CMD_WANT_CNT;
      end else if (wr_cnt) begin
        cmd_stage_reg.cnt <= wdata_i;
        cmd_phase_reg <= CMD_WANT_DST;
      end else if (wr_dst) begin
        cmd_phase_reg <= CMD_WANT_SRC;
      end
      if (cmd_push) cmdq_wr_reg <= (cmdq_wr_reg == PW'(CMDF_DEPTH - 1)) ? '0 : cmdq_wr_reg + PW'(1);
      if (cmd_pop) cmdq_rd_reg <= (cmdq_rd_reg == PW'(CMDF_DEPTH - 1)) ? '0 : cmdq_rd_reg + PW'(1);
      if (cmd_push && !cmd_pop) cmdq_cnt_reg <= cmdq_cnt_reg + QW'(1);
      if (cmd_pop && !cmd_push) cmdq_cnt_reg <= cmdq_cnt_reg - QW'(1);
    end
  end

  // ==========================================================
  // DMA engine; halted engine leaves queued commands untouched
  always_ff @(posedge clk_i) begin
    if (clr) begin
      dma_state_reg <= DMA_IDLE;
      src_cntr_reg <= 32'h0;
      byte_cntr_reg <= 32'h0;
      dst_cntr_reg <= 32'h0;
      cmd_tag_reg <= 4'h0;
      dma_req_reg <= 1'b0;
    end else if (ce_i) begin
      case (dma_state_reg)
        DMA_IDLE: begin
          if (cmd_pop) begin
            src_cntr_reg <= cmdq_mem[cmdq_rd_reg].src;
            byte_cntr_reg <= cmdq_mem[cmdq_rd_reg].cnt;
            dst_cntr_reg <= cmdq_mem[cmdq_rd_reg].dst;
            cmd_tag_reg <= cmd_tag_reg + 4'h1;
            // Empty command: no memory request at all
            dma_req_reg <= cmdq_mem[cmdq_rd_reg].cnt != 32'h0;
            dma_state_reg <= (cmdq_mem[cmdq_rd_reg].cnt == 32'h0) ? DMA_FINISH : DMA_RUN;
          end
        end
        DMA_RUN: begin
          if (dma_ack_i) begin
            src_cntr_reg <= src_cntr_reg + `RTXC_DMA_STEP;
            dst_cntr_reg <= dst_cntr_reg + `RTXC_DMA_STEP;
            if (byte_cntr_reg <= `RTXC_DMA_STEP) begin
              byte_cntr_reg <= 32'h0;
              dma_req_reg <= 1'b0;
              dma_state_reg <= DMA_FINISH;
            end else begin
              byte_cntr_reg <= byte_cntr_reg - `RTXC_DMA_STEP;
            end
          end
        end
        DMA_FINISH: dma_state_reg <= DMA_IDLE;
        default: dma_state_reg <= DMA_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Interrupt status: write one to clear, a new event in the same cycle wins
  logic finish;
  assign finish = dma_state_reg == DMA_FINISH;
  always_ff @(posedge clk_i) begin
    if (clr) begin
      ccid_reg <= 4'h0;
      done_status_reg <= 1'b0;
      dma_done_reg <= 1'b0;
      q_done_reg <= 1'b0;
      seq_err_reg <= 1'b0;
      halted_reg <= 1'b0;
    end else if (ce_i) begin
      if (finish) begin
        ccid_reg <= cmd_tag_reg;
      end else if (wr_istat && wdata_i[3:0] != 4'h0) begin
        ccid_reg <= 4'h0;
      end
      done_status_reg <= finish || (done_status_reg && !(wr_istat && wdata_i[`RTXC_IS_DONE_STATUS]));
      dma_done_reg <= finish || (dma_done_reg && !(wr_istat && wdata_i[`RTXC_IS_DMA_DONE]));
      q_done_reg <= (finish && cmdq_cnt_reg == '0)
        || (q_done_reg && !(wr_istat && wdata_i[`RTXC_IS_Q_DONE]));
      seq_err_reg <= cmd_seq_bad || (seq_err_reg && !(wr_istat && wdata_i[`RTXC_IS_SEQ_ERR]));
      // Only soft clear or reset releases the halt
      if (cmd_seq_bad) halted_reg <= 1'b1;
    end
  end

  // ==========================================================
  // Outputs, all from flops
  assign rdata_o = rdata_reg;
  assign stall_o = stall_reg;
  assign bus_req_o = bus_req_reg;
  assign bus_word_o = bus_word_reg;
  assign multi_grant_req_o = multi_reg;
  assign dma_req_o = dma_req_reg;
  assign dma_addr_o = src_cntr_reg;
endmodule

// ### test/rtxc_checker.sv
`timescale 1ns/1ps
// ==========
// Port checker
module rtxc_checker (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire rtxc_pkg::rtxc_snoop_type snoop_i,
  input wire logic stall_o,
  input wire logic bus_req_o,
  input wire logic bus_grant_i,
  input wire rtxc_pkg::rtxc_busword_type bus_word_o,
  input wire logic dma_req_o,
  input wire logic [31:0] dma_addr_o,
  input wire logic dma_ack_i
);
  import rtxc_pkg::*;
  // One domain, so clock and reset are stated once
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);
  chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data not idle");
  chk_regs_readback: assert property (wr_i && (addr_i == 8'h80 || addr_i == 8'h84) ##2 rd_i &&
    addr_i == $past(addr_i, 2) |=> rdata_o == $past(wdata_i, 3)) else $error("register readback");
  chk_ptr_readback: assert property (wr_i && addr_i == 8'h88 ##2 rd_i && addr_i == 8'h88
    |=> rdata_o == ($past(wdata_i, 3) & 32'h0003003f)) else $error("tx pointer readback");
  chk_word_grant: assert property (bus_word_o.valid |-> $past(bus_req_o && bus_grant_i))
    else $error("word without grant");
  chk_stall_rise: assert property ($rose(stall_o) |-> $past(snoop_i.valid))
    else $error("stall without push");
  chk_stall_drop: assert property ($past(stall_o) && bus_word_o.valid |-> !stall_o)
    else $error("stall kept after pop");
  chk_dma_hold: assert property (dma_req_o && !dma_ack_i |=> dma_req_o)
    else $error("dma request dropped");
  chk_dma_step: assert property (dma_req_o && dma_ack_i ##1 dma_req_o
    |-> dma_addr_o == $past(dma_addr_o) + 32'h4) else $error("dma address step");
  cover property ($rose(stall_o));
  cover property (bus_word_o.valid);
  cover property (dma_req_o && dma_ack_i);
endmodule
bind rtxc_top rtxc_checker u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .snoop_i(snoop_i), .stall_o(stall_o), .bus_req_o(bus_req_o),
  .bus_grant_i(bus_grant_i), .bus_word_o(bus_word_o), .dma_req_o(dma_req_o), .dma_addr_o(dma_addr_o),
  .dma_ack_i(dma_ack_i));

// ### test/rtxc_far_model.sv
`timescale 1ns/1ps
// ==========
// Memory board and bus node model
module rtxc_far_model (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic stall_i,
  input wire logic req_i,
  input wire logic dreq_i,
  input wire logic gnt_en_i,
  input wire logic go_i,
  input wire logic [28:0] addr_i,
  output rtxc_pkg::rtxc_snoop_type snoop_o,
  output logic gnt_o,
  output logic ack_o,
  output logic held_o
);
  import rtxc_pkg::*;
  rtxc_snoop_type post_reg;
  assign held_o = post_reg.valid;
  // A write met by stall waits in the post buffer; idle lines toggle so no stale value passes
  always_ff @(posedge clk_i) begin
    snoop_o <= '{1'b0, ~snoop_o.addr, ~snoop_o.data};
    if (!reset_n_i) begin
      post_reg <= '0;
      snoop_o <= '0;
    end else if (go_i && stall_i) begin
      post_reg <= '{1'b1, addr_i, {3'h0, addr_i}};
    end else if (go_i) begin
      snoop_o <= '{1'b1, addr_i, {3'h0, addr_i}};
    end else if (held_o && !stall_i) begin
      snoop_o <= post_reg;
      post_reg <= '0;
    end
  end
  // Grant lags the request; ack every other cycle keeps the DMA slow
  always_ff @(posedge clk_i) begin
    gnt_o <= reset_n_i && gnt_en_i && req_i;
    ack_o <= reset_n_i && dreq_i && !ack_o;
  end
endmodule

// ### test/reflective_adapter_tx_control_test.sv
`timescale 1ns/1ps
// ==========
// Bench top
module reflective_adapter_tx_control_test;
  import rtxc_pkg::*;
  localparam int TD = 8;
  logic clk_i = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic go = 1'b0;
  logic gnt_en = 1'b0;
  logic stall, req, gnt, mgr, dreq, dack, held;
  logic [7:0] addr = 8'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata, daddr;
  logic [3:0] node = 4'h0;
  logic [1:0] bsz = 2'h0;
  logic [28:0] sa = 29'h0;
  rtxc_snoop_type snoop;
  rtxc_busword_type bw, w0, wl;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  int nw = 0;
  int nd = 0;
  logic [31:0] pat [4] = '{32'hffffffff, 32'h55555555, 32'haaaaaaaa, 32'h0};
  // Shallow FIFO keeps the fill short; fill and word-count expectations follow TD, last-word ones assume TD of 8
  rtxc_top #(.TXF_DEPTH(TD)) dut (.clk_i(clk_i), .reset_n_i(rst_n), .ce_i(1'b1), .addr_i(addr), .wdata_i(wd),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .snoop_i(snoop), .stall_o(stall), .node_id_pin_i(node), .blksz_pin_i(bsz),
    .bus_req_o(req), .bus_grant_i(gnt), .bus_word_o(bw), .multi_grant_req_o(mgr), .dma_req_o(dreq),
    .dma_addr_o(daddr), .dma_ack_i(dack));
  rtxc_far_model far (.clk_i(clk_i), .reset_n_i(rst_n), .stall_i(stall), .req_i(req), .dreq_i(dreq),
    .gnt_en_i(gnt_en), .go_i(go), .addr_i(sa), .snoop_o(snoop), .gnt_o(gnt), .ack_o(dack), .held_o(held));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // Cycle ceiling, bus words and DMA request cycles
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (bw.valid === 1'b1 && nw == 0) w0 <= bw;
    if (bw.valid === 1'b1) begin
      nw <= nw + 1;
      wl <= bw;
    end
    if (dreq === 1'b1) nd <= nd + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      finish_test;
    end
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      n_mismatch++;
    end
  endtask
  // Bus tasks leave one idle edge, so no strobe is driven twice in a step
  task automatic wreg(logic [7:0] a, logic [31:0] v);
    @(posedge clk_i);
    addr <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic rreg(logic [7:0] a, output logic [31:0] v);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic rchk(string n, logic [7:0] a, logic [31:0] e);
    logic [31:0] v;
    rreg(a, v);
    chk(n, e, v);
  endtask
  task automatic sw(logic [28:0] a);
    @(posedge clk_i);
    go <= 1'b1;
    sa <= a;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task automatic t_regs;
    logic [31:0] w, sum;
    sum = 32'h0;
    for (int i = 0; i < 28; i++) begin
      w = {8'h5a, 8'(i), 8'h3c, 8'(3 * i)};
      sum += w;
      rchk("prom", 8'(4 * i), w);
    end
    for (int i = 0; i < 4; i++) rchk("csum", 8'(112 + 4 * i), {24'h0, sum[8 * i +: 8]});
    foreach (pat[k]) begin
      wreg(8'h80, pat[k]);
      rchk("bic", 8'h80, pat[k]);
      wreg(8'h84, pat[k]);
      rchk("ctl", 8'h84, pat[k]);
      wreg(8'h88, pat[k]);
      rchk("txptr", 8'h88, pat[k] & 32'h0003003f);
    end
    wreg(8'h84, 32'hffffffff);
    wreg(8'ha4, 32'h0);
    @(posedge clk_i);
    rchk("ctl_clr", 8'h84, 32'h0);
    rchk("unmapped", 8'hc0, 32'h0);
  endtask
  task automatic t_tables;
    logic [31:0] v;
    for (int i = 0; i < 64; i++) begin
      wreg(8'h88, 32'(i));
      wreg(8'h8c, 32'(i) * 32'h9e3779b1);
      rchk("txent", 8'h8c, 32'(i) * 32'h9e3779b1);
    end
    for (int i = 0; i < 16; i++) begin
      v = (i[0] ? 32'h20000000 : 32'h0) | ((32'(i) * 32'h1357) & 32'h1801ffff);
      wreg(8'h90, 32'(i));
      wreg(8'h94, 32'(i));
      wreg(8'h98, v);
      rchk("rxent", 8'h98, v);
    end
  endtask
  task automatic t_sense;
    logic [31:0] v;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_i);
      node <= 4'(3 * k + 3);
      bsz <= 2'(k);
      repeat (6) @(posedge clk_i);
      rreg(8'h9c, v);
      chk("node_id", (k == 3) ? 32'h9 : 32'(3 * k + 3), {28'h0, v[3:0]});
      chk("blksz", (k == 1) ? 32'h10 : (k == 2) ? 32'h20 : 32'h8, {24'h0, v[15:8]});
    end
    wreg(8'h84, 32'h1);
    rreg(8'h9c, v);
    chk("online", 32'h1, {31'h0, v[16]});
    wreg(8'h84, 32'h0);
    rreg(8'h9c, v);
    chk("offline", 32'h0, {31'h0, v[16]});
    rchk("istat", 8'ha0, 32'h0);
  endtask
  task automatic t_dma;
    logic [31:0] v;
    foreach (pat[k]) begin
      wreg(8'ha8, pat[k]);
      wreg(8'hac, 32'h0);
      wreg(8'hb0, ~pat[k]);
      repeat (6) @(posedge clk_i);
      rchk("src", 8'hb4, pat[k]);
      rchk("dst", 8'hbc, ~pat[k]);
      rchk("done", 8'ha0, 32'h70 | 32'(k + 1));
      wreg(8'ha0, 32'hff);
    end
    chk("no_req", 32'h0, 32'(nd));
    wreg(8'ha8, 32'h100);
    wreg(8'hac, 32'h8);
    wreg(8'hb0, 32'h200);
    for (int i = 0; i < 60 && (nd == 0 || dreq !== 1'b0); i++) @(posedge clk_i);
    repeat (3) @(posedge clk_i);
    rchk("src_end", 8'hb4, 32'h108);
    wreg(8'hb0, 32'h0);
    rreg(8'ha0, v);
    chk("seq_err", 32'h1, {31'h0, v[7]});
    wreg(8'ha8, 32'h40);
    wreg(8'hac, 32'h0);
    wreg(8'hb0, 32'h0);
    repeat (6) @(posedge clk_i);
    rchk("halted", 8'hb4, 32'h108);
    wreg(8'ha4, 32'h0);
    @(posedge clk_i);
  endtask
  // Offline and closed-window writes must not count toward the fill
  task automatic t_snoop;
    wreg(8'h88, 32'h0);
    wreg(8'h8c, 32'habcde008);
    wreg(8'h88, 32'h1);
    wreg(8'h8c, 32'h0);
    wreg(8'h84, 32'h4);
    sw(29'h10);
    wreg(8'h84, 32'h5);
    sw(29'h2000);
    for (int j = 0; j < TD; j++) begin
      sw(29'(4 * j));
      chk("stall", 32'(j == TD - 1), {31'h0, stall});
      chk("multi", 32'(j + 1 >= TD / 2), {31'h0, mgr});
    end
    sw(29'(4 * TD));
    chk("held", 32'h1, {31'h0, held});
    chk("kept", 32'h0, 32'(nw));
    chk("req_off", 32'h0, {31'h0, req});
    gnt_en <= 1'b1;
    wreg(8'h84, 32'h7);
    for (int i = 0; i < 200 && nw < TD + 1; i++) @(posedge clk_i);
    repeat (4) @(posedge clk_i);
    chk("words", 32'(TD + 1), 32'(nw));
    chk("w_addr", 32'hcde00000, w0.addr[31:0]);
    chk("w_data", 32'h0, w0.data);
    chk("l_addr", 32'hcde00020, wl.addr[31:0]);
    chk("l_data", 32'h20, wl.data);
  endtask
  task automatic finish_test;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_n <= 1'b1;
    @(posedge clk_i);
    t_regs;
    t_tables;
    t_sense;
    t_dma;
    t_snoop;
    finish_test;
  end
endmodule
